// File: rtl/crf_gpr_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "crf_map.svh"
module crf_gpr_bank
   import crf_pkg::*;
#(
   parameter int NUM_SETS = 1
) (
   input wire logic clk,
   input wire logic srst,
   crf_gpr_if.bank gp
);
   typedef struct packed {
      crf_word_t [NUM_SETS*32-1:0] mem;
   } crf_bank_state_t;

   crf_bank_state_t state_reg;
   crf_bank_state_t state_next;
   logic wrOk;

   // one word per set and entry
   function automatic crf_word_t readWord(crf_bank_state_t s, crf_set_t set,
                                          crf_idx_t idx);
      crf_word_t w;
      w = `CRF_WORD_RST;
      if (int'(set) < NUM_SETS && idx != `CRF_GPR_ZERO &&
          !(idx == `CRF_GPR_DBG && set != 6'h00)) begin
         w = s.mem[int'(set) * 32 + int'(idx)];
      end
      return w;
   endfunction

   always_comb begin
      wrOk = gp.wrEn && int'(gp.wrSet) < NUM_SETS;
      if (gp.wrIdx == `CRF_GPR_ZERO) begin
         wrOk = 1'b0;
      end
      if (gp.wrIdx == `CRF_GPR_DBG &&
          (gp.wrSet != 6'h00 || !gp.dbgEn)) begin
         wrOk = 1'b0;
      end
      state_next = state_reg;
      if (wrOk) begin
         state_next.mem[int'(gp.wrSet) * 32 + int'(gp.wrIdx)] = gp.wrData;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign gp.rdDataA = readWord(state_reg, gp.rdSet, gp.rdIdxA);
   assign gp.rdDataB = readWord(state_reg, gp.rdSet, gp.rdIdxB);
   assign gp.linkData = readWord(state_reg, gp.rdSet, `CRF_GPR_LINK);
endmodule
`default_nettype wire

// File: rtl/crf_gpr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface crf_gpr_if;
   import crf_pkg::*;
   logic wrEn;
   logic dbgEn;
   crf_set_t wrSet;
   crf_idx_t wrIdx;
   crf_word_t wrData;
   crf_set_t rdSet;
   crf_idx_t rdIdxA;
   crf_idx_t rdIdxB;
   crf_word_t rdDataA;
   crf_word_t rdDataB;
   crf_word_t linkData;

   modport bank (
      input wrEn, dbgEn, wrSet, wrIdx, wrData, rdSet, rdIdxA, rdIdxB,
      output rdDataA, rdDataB, linkData
   );
   modport ctl (
      output wrEn, dbgEn, wrSet, wrIdx, wrData, rdSet, rdIdxA, rdIdxB,
      input rdDataA, rdDataB, linkData
   );
endinterface
`default_nettype wire

// File: rtl/crf_map.svh
`ifndef CRF_MAP_SVH
`define CRF_MAP_SVH

`define CRF_IDX_STATUS 5'h00
`define CRF_IDX_ESTATE 5'h01
`define CRF_IDX_BSTATE 5'h02
`define CRF_IDX_IRQMASK 5'h03
`define CRF_IDX_IRQWAIT 5'h04
`define CRF_IDX_PROCID 5'h05
`define CRF_IDX_EXCCAUSE 5'h07
`define CRF_IDX_PTBASE 5'h08
`define CRF_IDX_XLACC 5'h09
`define CRF_IDX_XLMISC 5'h0A
`define CRF_IDX_FAULTADDR 5'h0C
`define CRF_IDX_MPUCFG 5'h0D
`define CRF_IDX_RGNBASE 5'h0E
`define CRF_IDX_RGNACC 5'h0F

`define CRF_GPR_ZERO 5'h00
`define CRF_GPR_DBG 5'h19
`define CRF_GPR_SAVED 5'h1E
`define CRF_GPR_LINK 5'h1F

`define CRF_ST_PIE 0
`define CRF_ST_USER 1
`define CRF_ST_CUR_LO 10
`define CRF_ST_PREV_LO 16
`define CRF_ST_NMI 22
`define CRF_ST_RSIE 23
`define CRF_ST_WMASK 32'h00BF_FFFF
`define CRF_CFG_MPUEN 0

`define CRF_STATUS_RST 32'h0000_0000
`define CRF_WORD_RST 32'h0000_0000

`endif

// File: rtl/crf_pkg.sv
package crf_pkg;
   typedef logic [31:0] crf_word_t;
   typedef logic [4:0] crf_idx_t;
   typedef logic [5:0] crf_set_t;

   typedef struct packed {
      crf_word_t status;
      crf_word_t estate;
      crf_word_t bstate;
      crf_word_t irqMask;
      crf_word_t excCause;
      crf_word_t faultAddr;
      crf_word_t ptBase;
      crf_word_t xlAcc;
      crf_word_t xlMisc;
      crf_word_t mpuCfg;
      crf_word_t rgnBase;
      crf_word_t rgnAcc;
      crf_word_t ctlRdata;
      logic ctlRdValid;
      logic privFault;
   } crf_ctl_state_t;
endpackage

// File: rtl/crf_register_file.sv
`timescale 1ns/1ps
`default_nettype none
`include "crf_map.svh"
module crf_register_file
   import crf_pkg::*;
#(
   parameter int NUM_SETS = 2,
   parameter bit HAS_MMU = 1'b0,
   parameter bit HAS_MPU = 1'b1,
   parameter bit HAS_XIRQ = 1'b0,
   // identifier value is arbitrary
   parameter logic [31:0] CPU_ID = 32'h0000_0000
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [4:0] rdIdxA,
   input wire logic [4:0] rdIdxB,
   output logic [31:0] rdDataA,
   output logic [31:0] rdDataB,
   input wire logic gprWrEn,
   input wire logic [4:0] gprWrIdx,
   input wire logic [31:0] gprWrData,
   input wire logic callLink,
   input wire logic [31:0] linkAddr,
   output logic [31:0] linkAddress,
   input wire logic dbgAccess,
   input wire logic ctlRdEn,
   input wire logic ctlWrEn,
   input wire logic [4:0] ctlIdx,
   input wire logic [31:0] ctlWdata,
   output logic [31:0] ctlRdata,
   output logic ctlRdValid,
   output logic privFault,
   input wire logic excEnter,
   input wire logic [5:0] excSet,
   input wire logic [31:0] excCauseIn,
   input wire logic [31:0] excAddrIn,
   input wire logic [31:0] irqLines,
   output logic [5:0] currentSet,
   output logic userMode,
   output logic mpuEnable
);
   localparam int SET_BITS = (NUM_SETS > 1) ? $clog2(NUM_SETS) : 0;
   localparam logic [5:0] SET_MASK = 6'((64'h1 << SET_BITS) - 64'h1);
   localparam bit HAS_USER = HAS_MMU || HAS_MPU;

   crf_ctl_state_t state_reg;
   crf_ctl_state_t state_next;
   crf_gpr_if gp ();

   crf_word_t statusRst;
   crf_word_t irqWait;
   crf_word_t rdVal;
   crf_word_t wrVal;
   crf_set_t curSet;
   crf_set_t newSet;
   logic supMode;
   logic ctlReq;

   crf_gpr_bank #(
      .NUM_SETS(NUM_SETS)
   ) u_bank (
      .clk(clk),
      .srst(srst),
      .gp(gp)
   );

   always_comb begin
      statusRst = `CRF_STATUS_RST;
      statusRst[`CRF_ST_RSIE] = HAS_XIRQ && NUM_SETS > 1;
      curSet = state_reg.status[`CRF_ST_CUR_LO +: 6] & SET_MASK;
      newSet = excSet & SET_MASK;
      supMode = !state_reg.status[`CRF_ST_USER];
      ctlReq = ctlRdEn || ctlWrEn;
      irqWait = HAS_XIRQ ? `CRF_WORD_RST
                        : (irqLines & state_reg.irqMask);
   end

   // general register port; shadow saved state beats calls beats writes
   always_comb begin
      gp.rdSet = curSet;
      gp.rdIdxA = rdIdxA;
      gp.rdIdxB = rdIdxB;
      gp.dbgEn = dbgAccess;
      gp.wrEn = gprWrEn;
      gp.wrSet = curSet;
      gp.wrIdx = gprWrIdx;
      gp.wrData = gprWrData;
      if (callLink) begin
         gp.wrEn = 1'b1;
         gp.wrIdx = `CRF_GPR_LINK;
         gp.wrData = linkAddr;
      end
      if (excEnter && newSet != 6'h00) begin
         gp.wrEn = 1'b1;
         gp.wrSet = newSet;
         gp.wrIdx = `CRF_GPR_SAVED;
         gp.wrData = state_reg.status;
      end
   end

   // control register read decode
   always_comb begin
      rdVal = `CRF_WORD_RST;
      unique case (ctlIdx)
         `CRF_IDX_STATUS: rdVal = state_reg.status;
         `CRF_IDX_ESTATE: rdVal = state_reg.estate;
         `CRF_IDX_BSTATE: rdVal = state_reg.bstate;
         `CRF_IDX_IRQMASK: rdVal = HAS_XIRQ ? `CRF_WORD_RST
                                            : state_reg.irqMask;
         `CRF_IDX_IRQWAIT: rdVal = irqWait;
         `CRF_IDX_PROCID: rdVal = CPU_ID;
         `CRF_IDX_EXCCAUSE: rdVal = state_reg.excCause;
         `CRF_IDX_PTBASE: rdVal = HAS_MMU ? state_reg.ptBase
                                          : `CRF_WORD_RST;
         `CRF_IDX_XLACC: rdVal = HAS_MMU ? state_reg.xlAcc : `CRF_WORD_RST;
         `CRF_IDX_XLMISC: rdVal = HAS_MMU ? state_reg.xlMisc : `CRF_WORD_RST;
         `CRF_IDX_FAULTADDR: rdVal = state_reg.faultAddr;
         `CRF_IDX_MPUCFG: rdVal = HAS_MPU ? state_reg.mpuCfg
                                          : `CRF_WORD_RST;
         `CRF_IDX_RGNBASE: rdVal = HAS_MPU ? state_reg.rgnBase : `CRF_WORD_RST;
         `CRF_IDX_RGNACC: rdVal = HAS_MPU ? state_reg.rgnAcc : `CRF_WORD_RST;
         default: rdVal = `CRF_WORD_RST;
      endcase
   end

   // status write keeps only defined bits and masks set numbers to SET_BITS bits
   always_comb begin
      wrVal = ctlWdata & `CRF_ST_WMASK;
      wrVal[`CRF_ST_NMI] = state_reg.status[`CRF_ST_NMI];
      wrVal[`CRF_ST_CUR_LO +: 6] = ctlWdata[`CRF_ST_CUR_LO +: 6]
                                   & SET_MASK;
      wrVal[`CRF_ST_PREV_LO +: 6] = ctlWdata[`CRF_ST_PREV_LO +: 6]
                                    & SET_MASK;
      if (!HAS_USER) begin
         wrVal[`CRF_ST_USER] = 1'b0;
      end
      if (!(HAS_XIRQ && NUM_SETS > 1)) begin
         wrVal[`CRF_ST_RSIE] = statusRst[`CRF_ST_RSIE];
      end
   end

   always_comb begin
      state_next = state_reg;
      state_next.ctlRdValid = 1'b0;
      state_next.privFault = ctlReq && !supMode;
      if (ctlRdEn && supMode) begin
         state_next.ctlRdata = rdVal;
         state_next.ctlRdValid = 1'b1;
      end
      if (ctlWrEn && supMode) begin
         unique case (ctlIdx)
            `CRF_IDX_STATUS: state_next.status = wrVal;
            `CRF_IDX_ESTATE: state_next.estate = ctlWdata;
            `CRF_IDX_BSTATE: state_next.bstate = ctlWdata;
            `CRF_IDX_IRQMASK: begin
               if (!HAS_XIRQ) begin
                  state_next.irqMask = ctlWdata;
               end
            end
            `CRF_IDX_PTBASE: begin
               if (HAS_MMU) begin
                  state_next.ptBase = ctlWdata;
               end
            end
            `CRF_IDX_XLACC: begin
               if (HAS_MMU) begin
                  state_next.xlAcc = ctlWdata;
               end
            end
            `CRF_IDX_XLMISC: begin
               if (HAS_MMU) begin
                  state_next.xlMisc = ctlWdata;
               end
            end
            `CRF_IDX_MPUCFG: begin
               if (HAS_MPU) begin
                  state_next.mpuCfg = ctlWdata;
               end
            end
            `CRF_IDX_RGNBASE: begin
               if (HAS_MPU) begin
                  state_next.rgnBase = ctlWdata;
               end
            end
            `CRF_IDX_RGNACC: begin
               if (HAS_MPU) begin
                  state_next.rgnAcc = ctlWdata;
               end
            end
            default: state_next.status = state_reg.status;
         endcase
      end
      // exception entry saves state and moves to the requested set
      if (excEnter) begin
         state_next.estate = state_reg.status;
         state_next.excCause = excCauseIn;
         state_next.faultAddr = excAddrIn;
         state_next.status[`CRF_ST_PREV_LO +: 6] = curSet;
         state_next.status[`CRF_ST_CUR_LO +: 6] = newSet;
         state_next.status[`CRF_ST_USER] = 1'b0;
         state_next.status[`CRF_ST_PIE] = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg <= '0;
         state_reg.status <= `CRF_STATUS_RST;
         state_reg.status[`CRF_ST_RSIE] <= HAS_XIRQ && NUM_SETS > 1;
         state_reg.mpuCfg <= `CRF_WORD_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdDataA = gp.rdDataA;
   assign rdDataB = gp.rdDataB;
   assign linkAddress = gp.linkData;
   assign ctlRdata = state_reg.ctlRdata;
   assign ctlRdValid = state_reg.ctlRdValid;
   assign privFault = state_reg.privFault;
   assign currentSet = curSet;
   assign userMode = state_reg.status[`CRF_ST_USER];
   assign mpuEnable = HAS_MPU && state_reg.mpuCfg[`CRF_CFG_MPUEN];
endmodule
`default_nettype wire

// File: tb/crf_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
module crf_pipe_model
   import crf_pkg::*;
(
   input wire logic clk,
   output logic ctlRdEn,
   output logic ctlWrEn,
   output logic [4:0] ctlIdx,
   output logic [31:0] ctlWdata,
   input wire logic [31:0] ctlRdata,
   input wire logic ctlRdValid,
   input wire logic privFault
);
   initial begin
      {ctlRdEn, ctlWrEn, ctlIdx, ctlWdata} = '0;
   end
   // one control instruction; valid and fault stand one cycle only, the read data holds
   task automatic ctl(input logic wr, input crf_idx_t i, input crf_word_t d,
         output crf_word_t q, output logic v, output logic f);
      @(negedge clk);
      ctlRdEn <= !wr;
      ctlWrEn <= wr;
      ctlIdx <= i;
      ctlWdata <= (i == 5'h00) ? (d & 32'h00BF_FFFF) : d;
      @(negedge clk);
      q = ctlRdata;
      v = ctlRdValid;
      f = privFault;
      ctlRdEn <= 1'h0;
      ctlWrEn <= 1'h0;
      ctlIdx <= ~i;
      ctlWdata <= ~ctlWdata;
   endtask
endmodule
`default_nettype wire

// File: tb/crf_register_file_bench.sv
`timescale 1ns/1ps
`default_nettype none
module crf_register_file_bench;
   import crf_pkg::*;
   // identifier value is arbitrary
   localparam logic [31:0] ID = 32'h0000_5A3C;
   logic clk, srst, gprWrEn, callLink, dbgAccess, excEnter, ctlRdValid;
   logic privFault, userMode, mpuEnable, ctlRdEn, ctlWrEn, v, f;
   logic [4:0] rdIdxA, rdIdxB, gprWrIdx, ctlIdx;
   logic [5:0] excSet, currentSet;
   logic [31:0] rdDataA, rdDataB, gprWrData, linkAddr, linkAddress, ctlWdata;
   logic [31:0] ctlRdata, excCauseIn, excAddrIn, irqLines, q, r, seed;
   crf_word_t gm [2][32] = '{default: 32'h0};
   crf_word_t st = 0, es = 0, im = 0, ec = 0, fa = 0, mc = 0, rb = 0, rg = 0;
   int cs = 0, fail_count = 0, compares = 0;
   crf_register_file #(.CPU_ID(ID)) dut (.clk, .srst, .rdIdxA, .rdIdxB,
      .rdDataA, .rdDataB, .gprWrEn, .gprWrIdx, .gprWrData, .callLink,
      .linkAddr, .linkAddress, .dbgAccess, .ctlRdEn, .ctlWrEn, .ctlIdx,
      .ctlWdata, .ctlRdata, .ctlRdValid, .privFault, .excEnter, .excSet,
      .excCauseIn, .excAddrIn, .irqLines, .currentSet, .userMode,
      .mpuEnable);
   crf_pipe_model pipe (.clk, .ctlRdEn, .ctlWrEn, .ctlIdx, .ctlWdata,
      .ctlRdata, .ctlRdValid, .privFault);
   task automatic chk(input string n, input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic results;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   function automatic crf_word_t ex(input crf_idx_t i);
      case (i)
         5'h00: return st;
         5'h01: return es;
         5'h03: return im;
         5'h04: return irqLines & im;
         5'h05: return ID;
         5'h07: return ec;
         5'h0C: return fa;
         5'h0D: return mc;
         5'h0E: return rb;
         5'h0F: return rg;
         default: return 32'h0;
      endcase
   endfunction
   task automatic cr(input crf_idx_t i);
      pipe.ctl(1'h0, i, 32'h0, q, v, f);
      chk("ctlValid", v, 1'h1);
      chk("ctlData", q, ex(i));
   endtask
   task automatic cw(input crf_idx_t i, input crf_word_t d);
      pipe.ctl(1'h1, i, d, q, v, f);
      chk("ctlFault", f, 1'h0);
      case (i)
         5'h00: st = d;
         5'h03: im = d;
         5'h0D: mc = d;
         5'h0E: rb = d;
         5'h0F: rg = d;
         default: ;
      endcase
   endtask
   task automatic gw(input crf_idx_t i, input crf_word_t d, input logic dbg,
         input logic cl);
      @(negedge clk);
      {gprWrEn, gprWrIdx, gprWrData, dbgAccess, callLink} = {1'h1, i, d, dbg, cl};
      linkAddr = ~d;
      if (cl)
         gm[cs][31] = ~d;
      else if (i != 0 && (i != 25 || (dbg && cs == 0)))
         gm[cs][i] = d;
      @(negedge clk);
      {gprWrEn, callLink, gprWrData} = {2'h0, ~d};
   endtask
   task automatic gr(input crf_idx_t i);
      @(negedge clk);
      {rdIdxA, rdIdxB} = {i, ~i};
      #1;
      chk("gprA", rdDataA, gm[cs][i]);
      chk("gprB", rdDataB, gm[cs][~i]);
      chk("link", linkAddress, gm[cs][31]);
   endtask
   task automatic exc;
      @(negedge clk);
      {excEnter, excSet, excCauseIn, excAddrIn} = {1'h1, 6'h01, q, ~q};
      {es, gm[1][30], ec, fa, cs} = {st, st, q, ~q, 32'h1};
      st = {st[31:22], 5'h00, st[10], 5'h00, 1'h1, st[9:2], 2'h0};
      @(negedge clk);
      excEnter = 1'h0;
   endtask
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      results;
   end
   initial begin
      seed = 32'hebd9;
      {srst, gprWrEn, callLink, dbgAccess, excEnter} = 5'h10;
      {rdIdxA, rdIdxB, gprWrIdx, excSet, gprWrData, linkAddr} = '0;
      {excCauseIn, excAddrIn, irqLines} = '0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      srst = 1'h0;
      chk("mpuEn", mpuEnable, 1'h0);
      for (int i = 0; i < 32; i++) cr(i[4:0]);
      $display("test reset done");
      gw(5'h00, 32'hFFFF_FFFF, 1'h1, 1'h0);
      gw(5'h19, 32'h1234_5678, 1'h0, 1'h0);
      for (int i = 0; i < 64; i++) begin
         r = $random(seed);
         gw(r[4:0], $random(seed), r[5], r[8:6] == 3'h0);
      end
      for (int i = 0; i < 32; i++) gr(i[4:0]);
      $display("test general registers done");
      @(negedge clk);
      irqLines = $random(seed);
      cw(5'h03, $random(seed));
      cw(5'h0E, $random(seed));
      cw(5'h0F, $random(seed));
      cw(5'h0D, 32'h1);
      chk("mpuEn", mpuEnable, 1'h1);
      for (int i = 4; i < 32; i += 3) cw(i[4:0], $random(seed));
      cw(5'h00, 32'h1);
      for (int i = 0; i < 16; i++) cr(i[4:0]);
      $display("test control registers done");
      q = $random(seed);
      exc;
      chk("set", currentSet, 6'h01);
      gw(5'h19, 32'hA5A5_A5A5, 1'h1, 1'h0);
      for (int i = 0; i < 32; i++) gr(i[4:0]);
      for (int i = 0; i < 13; i++) cr(i[4:0]);
      cw(5'h00, 32'h0000_0402);
      chk("user", userMode, 1'h1);
      pipe.ctl(1'h1, 5'h03, 32'hFFFF_FFFF, q, v, f);
      chk("fault", f, 1'h1);
      pipe.ctl(1'h0, 5'h05, 32'h0, q, v, f);
      chk("fault", {v, f}, 2'h1);
      q = $random(seed);
      exc;
      for (int i = 0; i < 4; i++) cr(i[4:0]);
      $display("test user mode done");
      results;
   end
endmodule
`default_nettype wire

// File: tb/crf_register_file_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module crf_register_file_monitor
   import crf_pkg::*;
#(
   parameter int NUM_SETS = 2,
   parameter logic [31:0] CPU_ID = 32'h0000_0000
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [4:0] rdIdxA,
   input wire logic [31:0] rdDataA,
   input wire logic callLink,
   input wire logic [31:0] linkAddr,
   input wire logic [31:0] linkAddress,
   input wire logic ctlRdEn,
   input wire logic ctlWrEn,
   input wire logic [4:0] ctlIdx,
   input wire logic [31:0] ctlWdata,
   input wire logic [31:0] ctlRdata,
   input wire logic ctlRdValid,
   input wire logic privFault,
   input wire logic excEnter,
   input wire logic [5:0] currentSet,
   input wire logic userMode,
   input wire logic mpuEnable
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence supRd;
      ctlRdEn && !userMode;
   endsequence
   sequence usrReq;
      (ctlRdEn || ctlWrEn) && userMode;
   endsequence
   AST_ZERO: assert property (rdIdxA == 5'h00 |-> rdDataA == 32'h0)
      else $error("entry zero not zero");
   AST_MPU_RST: assert property ($fell(srst) |-> !mpuEnable)
      else $error("mpu enabled after reset");
   AST_SUP_RD: assert property (supRd |=> ctlRdValid && !privFault)
      else $error("supervisor read not answered");
   AST_USER: assert property (usrReq |=> privFault && !ctlRdValid)
      else $error("user access not refused");
   AST_CPUID: assert property (supRd ##0 ctlIdx == 5'h05 |=>
      ctlRdata == CPU_ID) else $error("identifier wrong");
   AST_RSV: assert property (supRd ##0 (ctlIdx == 5'h06 || ctlIdx > 5'h0F)
      |=> ctlRdata == 32'h0) else $error("reserved read not zero");
   AST_MPU_WR: assert property (ctlWrEn && !userMode && ctlIdx == 5'h0D
      && !excEnter |=> mpuEnable == $past(ctlWdata[0]))
      else $error("mpu enable not written");
   AST_LINK: assert property (callLink && !excEnter && !ctlWrEn |=>
      linkAddress == $past(linkAddr)) else $error("link entry wrong");
   AST_SET: assert property (currentSet < NUM_SETS)
      else $error("current set out of range");
endmodule
bind crf_register_file crf_register_file_monitor #(.NUM_SETS(NUM_SETS),
   .CPU_ID(CPU_ID)) mon (.clk, .srst, .rdIdxA, .rdDataA, .callLink,
   .linkAddr, .linkAddress, .ctlRdEn, .ctlWrEn, .ctlIdx, .ctlWdata,
   .ctlRdata, .ctlRdValid, .privFault, .excEnter, .currentSet, .userMode,
   .mpuEnable);
`default_nettype wire
